// >>> logic/eepl_regs.svh
`ifndef EEPL_REGS_SVH
`define EEPL_REGS_SVH

// register byte offsets on the AXI4-Lite slave
`define EEPL_OFF_ACR 8'h00
`define EEPL_OFF_DIVH 8'h04
`define EEPL_OFF_DIVL 8'h08
`define EEPL_OFF_STAT 8'h0c

// eeprom-side addresses
`define EEPL_ARRAY_LO 16'h0800
`define EEPL_ARRAY_HI 16'h09ff
`define EEPL_SECURE_LO 16'h08f0
`define EEPL_SECURE_HI 16'h08ff
`define EEPL_ADDR_CFG_NV 16'h0a00
`define EEPL_ADDR_DIVH_NV 16'h0a01
`define EEPL_ADDR_DIVL_NV 16'h0a02

// field positions
`define EEPL_BLK_SHIFT 7
`define EEPL_BLK_LSB_IDX 9'h000
`define EEPL_LOCK_BIT 4
`define EEPL_DIVSEC_BIT 7

// reset values of the volatile copies (erased cells read as one)
`define EEPL_ACR_RST 8'hff
`define EEPL_DIVH_RST 8'hff
`define EEPL_DIVL_RST 8'hff

// axi responses
`define EEPL_RESP_OKAY 2'b00
`define EEPL_RESP_SLVERR 2'b10

`endif

// >>> logic/eepl_pkg.sv
package eepl_pkg;

  // access kinds the processor core issues to the eeprom
  typedef enum logic [2:0] {
    EEPL_OP_READ,
    EEPL_OP_PROG_BYTE,
    EEPL_OP_ERASE_BYTE,
    EEPL_OP_ERASE_BLOCK,
    EEPL_OP_ERASE_BULK
  } eepl_op_t;

  // outcome of a protection check
  typedef enum logic [2:0] {
    EEPL_OK,
    EEPL_DENY_SECURE,
    EEPL_DENY_CFG_LOCK,
    EEPL_DENY_MULTI_ERASE,
    EEPL_DENY_BLOCK,
    EEPL_DENY_DIV_LOCK,
    EEPL_DENY_UNMAPPED
  } eepl_reason_t;

  typedef struct packed {
    eepl_op_t op;
    logic [15:0] addr;
  } eepl_req_t;

  typedef struct packed {
    logic granted;
    logic hv_start;
    eepl_reason_t reason;
  } eepl_resp_t;

  // volatile array configuration copy; lock bit low means armed
  typedef struct packed {
    logic [2:0] spare;
    logic lock_n;
    logic [3:0] block_protect_bits;
  } eepl_acr_t;

endpackage : eepl_pkg

// >>> logic/eepl_protect.sv
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "eepl_regs.svh"

// Operation
// [R1] 0x08F0-0x08FF is the secured region
// [R2] armed lock refuses program/erase in secured region
// [R3] secured region still reads normally
// [R4] armed lock blocks config register program/erase
// [R5] armed lock rejects block and bulk erase
// [R6] armed: byte ops allowed outside protected blocks
// [R7] armed lock freezes configuration register settings
// [R8] four 128-byte blocks, protect bit inhibits
// [R9] protect bit n covers block n upward; the code protects block n only
// [R10] protect applied at reset or config read
// [R11] armed divider secure bit reloads as zero
// [R12] divider security blocks divider nonvolatile program/erase
// [R13] divider security ignores volatile divider writes
// [R14] reset copies nonvolatile into volatile registers
// [R15] programmed cell is zero, erased is one
// [R16] refused request starts no high voltage
module eepl_protect
  import eepl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // nonvolatile cell contents from the array
  input wire logic [7:0] array_config_nonvolatile,
  input wire logic [7:0] divider_high_nonvolatile,
  input wire logic [7:0] divider_low_nonvolatile,
  // eeprom access requests from the core
  input wire logic req_valid,
  input wire eepl_req_t req,
  output logic req_ready,
  output logic resp_valid,
  output eepl_resp_t resp,
  // divider value to the timebase generator
  output logic [15:0] divider_value
);

  eepl_acr_t acr_q;
  logic [7:0] divh_q;
  logic [7:0] divl_q;
  logic load_pend_q;
  logic req_fire;
  eepl_reason_t chk;
  logic armed;
  logic div_armed;
  logic resp_valid_q;
  eepl_resp_t resp_q;
  logic [7:0] deny_cnt_q;
  eepl_reason_t last_deny_q;

  // protection decision for one access
  function automatic eepl_reason_t check(input eepl_req_t r, input eepl_acr_t a,
                                         input logic dsec);
    logic in_array;
    logic [1:0] blk;
    logic lock;
    logic multi;
    in_array = (r.addr >= `EEPL_ARRAY_LO) && (r.addr <= `EEPL_ARRAY_HI);
    blk = r.addr[`EEPL_BLK_SHIFT+1:`EEPL_BLK_SHIFT]; // [R9]
    lock = ~a.lock_n; // [R15]
    multi = (r.op == EEPL_OP_ERASE_BLOCK) || (r.op == EEPL_OP_ERASE_BULK);
    if (r.op == EEPL_OP_READ) begin
      check = EEPL_OK; // [R3]
    end else if (r.addr == `EEPL_ADDR_CFG_NV) begin
      check = lock ? EEPL_DENY_CFG_LOCK : EEPL_OK; // [R4]
    end else if (r.addr == `EEPL_ADDR_DIVH_NV || r.addr == `EEPL_ADDR_DIVL_NV) begin
      check = dsec ? EEPL_DENY_DIV_LOCK : EEPL_OK; // [R12]
    end else if (!in_array) begin
      check = EEPL_DENY_UNMAPPED;
    end else if (lock && multi) begin
      check = EEPL_DENY_MULTI_ERASE; // [R5]
    end else if (lock && r.addr >= `EEPL_SECURE_LO && r.addr <= `EEPL_SECURE_HI) begin
      check = EEPL_DENY_SECURE; // [R1] [R2]
    end else if (r.op == EEPL_OP_ERASE_BULK && (|a.block_protect_bits)) begin
      check = EEPL_DENY_BLOCK; // [R8]
    end else if (a.block_protect_bits[blk]) begin
      check = EEPL_DENY_BLOCK; // [R6] [R8]
    end else begin
      check = EEPL_OK;
    end
  endfunction : check

  assign armed = ~acr_q.lock_n;
  assign div_armed = ~divh_q[`EEPL_DIVSEC_BIT];
  assign chk = check(req, acr_q, div_armed);
  // requests wait until the reset-time copy has been made
  assign req_ready = ce & ~load_pend_q;
  assign req_fire = req_valid & req_ready;
  assign resp_valid = resp_valid_q;
  assign resp = resp_q;
  assign divider_value = {divh_q, divl_q};

  // one load cycle after reset release; the copy is taken clocked, never in reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_pend_q <= 1'b1;
    end else if (ce) begin
      load_pend_q <= 1'b0;
    end
  end

  // volatile array configuration: reset copy or refresh on config read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acr_q <= `EEPL_ACR_RST;
    end else if (ce) begin
      if (load_pend_q) begin
        acr_q <= array_config_nonvolatile; // [R14]
      end else if (req_fire && req.op == EEPL_OP_READ && req.addr == `EEPL_ADDR_CFG_NV
                   && !armed) begin
        acr_q <= array_config_nonvolatile; // [R10] [R7]
      end
    end
  end

  // request answer, registered one cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_valid_q <= 1'b0;
      resp_q <= '0;
    end else if (ce) begin
      resp_valid_q <= req_fire;
      if (req_fire) begin
        resp_q.granted <= (chk == EEPL_OK);
        resp_q.hv_start <= (chk == EEPL_OK) && (req.op != EEPL_OP_READ); // [R16]
        resp_q.reason <= chk;
      end
    end
  end

  // refusal bookkeeping for software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      deny_cnt_q <= 8'h00;
      last_deny_q <= EEPL_OK;
    end else if (ce && req_fire && chk != EEPL_OK) begin
      deny_cnt_q <= deny_cnt_q + 8'h01; // wraps; software takes differences
      last_deny_q <= chk;
    end
  end

  // ---- axi4-lite write channel: address and data taken in either order
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_strb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_do;

  assign s_axi_awready = ce & ~aw_have_q & ~bvalid_q;
  assign s_axi_wready = ce & ~w_have_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign wr_do = ce & aw_have_q & w_have_q & ~bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 8'h00;
      w_strb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `EEPL_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_strb0_q <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        case (aw_addr_q)
          `EEPL_OFF_ACR, `EEPL_OFF_DIVH, `EEPL_OFF_DIVL, `EEPL_OFF_STAT: begin
            bresp_q <= `EEPL_RESP_OKAY;
          end
          default: begin
            bresp_q <= `EEPL_RESP_SLVERR;
          end
        endcase
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // volatile divider registers; secure bit only comes from the nonvolatile copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divh_q <= `EEPL_DIVH_RST;
      divl_q <= `EEPL_DIVL_RST;
    end else if (ce) begin
      if (load_pend_q) begin
        divh_q <= divider_high_nonvolatile; // [R14] [R11]
        divl_q <= divider_low_nonvolatile; // [R14]
      end else if (wr_do && w_strb0_q && !div_armed) begin // [R13]
        if (aw_addr_q == `EEPL_OFF_DIVH) begin
          divh_q[6:0] <= w_data_q[6:0];
        end
        if (aw_addr_q == `EEPL_OFF_DIVL) begin
          divl_q <= w_data_q;
        end
      end
    end
  end

  // ---- axi4-lite read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  assign s_axi_arready = ce & ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `EEPL_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rresp_q <= `EEPL_RESP_OKAY;
        case (s_axi_araddr)
          `EEPL_OFF_ACR: rdata_q <= {24'h000000, acr_q};
          `EEPL_OFF_DIVH: rdata_q <= {24'h000000, divh_q};
          `EEPL_OFF_DIVL: rdata_q <= {24'h000000, divl_q};
          `EEPL_OFF_STAT: rdata_q <= {16'h0000, 4'h0, div_armed, last_deny_q, deny_cnt_q};
          default: begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= `EEPL_RESP_SLVERR;
          end
        endcase
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ---- checks
  sequence s_fire(logic c);
    ce && req_fire && c;
  endsequence

  sequence s_refused;
    resp_valid && !resp.granted && !resp.hv_start;
  endsequence

  logic in_sec;
  logic is_pe;
  assign in_sec = req.addr >= `EEPL_SECURE_LO && req.addr <= `EEPL_SECURE_HI;
  assign is_pe = req.op != EEPL_OP_READ;

  property p_secure_deny;
    @(posedge aclk) disable iff (!aresetn)
    s_fire(armed && is_pe && in_sec) |=> s_refused;
  endproperty
  a_secure_deny: assert property (p_secure_deny) else $error("secured write let through"); // [R2]

  property p_secure_read;
    @(posedge aclk) disable iff (!aresetn)
    s_fire(req.op == EEPL_OP_READ && in_sec) |=> resp_valid && resp.granted;
  endproperty
  a_secure_read: assert property (p_secure_read) else $error("secured read refused"); // [R3]

  property p_cfg_lock;
    @(posedge aclk) disable iff (!aresetn)
    s_fire(armed && is_pe && req.addr == `EEPL_ADDR_CFG_NV) |=> s_refused;
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("config write let through"); // [R4]

  property p_multi_erase;
    @(posedge aclk) disable iff (!aresetn)
    s_fire(armed && (req.op == EEPL_OP_ERASE_BLOCK || req.op == EEPL_OP_ERASE_BULK))
      |=> s_refused;
  endproperty
  a_multi_erase: assert property (p_multi_erase) else $error("multi erase let through"); // [R5]

  property p_block;
    @(posedge aclk) disable iff (!aresetn)
    s_fire(is_pe && req.addr >= `EEPL_ARRAY_LO && req.addr <= `EEPL_ARRAY_HI
           && acr_q.block_protect_bits[req.addr[8:7]]) |=> s_refused;
  endproperty
  a_block: assert property (p_block) else $error("protected block altered"); // [R8]

  property p_freeze;
    @(posedge aclk) disable iff (!aresetn)
    armed && !load_pend_q ##1 !load_pend_q |-> $stable(acr_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("config changed while armed"); // [R7]

  property p_div_nv;
    @(posedge aclk) disable iff (!aresetn)
    s_fire(div_armed && is_pe && (req.addr == `EEPL_ADDR_DIVH_NV
           || req.addr == `EEPL_ADDR_DIVL_NV)) |=> s_refused;
  endproperty
  a_div_nv: assert property (p_div_nv) else $error("divider nv altered"); // [R12]

  property p_div_write;
    @(posedge aclk) disable iff (!aresetn)
    wr_do && div_armed && !load_pend_q |=> $stable(divider_value);
  endproperty
  a_div_write: assert property (p_div_write) else $error("divider written while secure"); // [R13]

  property p_hv;
    @(posedge aclk) disable iff (!aresetn)
    resp_valid && resp.hv_start |-> resp.granted && resp.reason == EEPL_OK;
  endproperty
  a_hv: assert property (p_hv) else $error("high voltage on refused request"); // [R16]

endmodule : eepl_protect

// >>> verif/eepl_core_model.sv
`timescale 1ns/1ps

// processor core side: turns a one-cycle command into a request held until taken
module eepl_core_model
  import eepl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cmd_valid,
  input wire eepl_req_t cmd,
  output logic cmd_done,
  output eepl_resp_t cmd_resp,
  output logic req_valid,
  output eepl_req_t req,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire eepl_resp_t resp
);
  logic busy_q = 1'b0;

  initial begin
    cmd_done = 1'b0;
    cmd_resp = '0;
    req_valid = 1'b0;
    req = '0;
  end

  // a released request bus shows inverted junk so a stale address never looks valid
  // every branch gives cmd_done its value once, so the strobe never gets two drives per edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      req_valid <= 1'b0;
      busy_q <= 1'b0;
      cmd_done <= 1'b0;
    end else if (!busy_q && cmd_valid) begin
      req_valid <= 1'b1;
      req <= cmd;
      busy_q <= 1'b1;
      cmd_done <= 1'b0;
    end else if (req_valid && req_ready) begin
      req_valid <= 1'b0;
      req <= eepl_req_t'(~req);
      cmd_done <= 1'b0;
    end else if (busy_q && resp_valid) begin
      busy_q <= 1'b0;
      cmd_done <= 1'b1;
      cmd_resp <= resp;
    end else begin
      cmd_done <= 1'b0;
    end
  end
endmodule : eepl_core_model

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`include "eepl_regs.svh"

module tb_top
  import eepl_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, req_valid, req_ready, resp_valid, cmd_done;
  logic [1:0] bresp, rresp, r;
  logic [7:0] cfg_nv = 8'hf2, divh_nv = 8'h92, divl_nv = 8'h34;
  logic [15:0] divider_value;
  logic cmd_valid = 1'b0;
  logic ce = 1'b1;
  eepl_req_t cmd = '0, req;
  eepl_resp_t resp, cmd_resp;
  logic [7:0] acr_m;
  logic dsec_m;
  logic [15:0] rnd = 16'h0044;
  int n_fail = 0, num_checks = 0;

  always #5 aclk = ~aclk;

  eepl_protect u_eepl_protect (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .array_config_nonvolatile(cfg_nv), .divider_high_nonvolatile(divh_nv),
    .divider_low_nonvolatile(divl_nv), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp),
    .divider_value(divider_value));

  eepl_core_model u_eepl_core_model (.aclk(aclk), .aresetn(aresetn), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_done(cmd_done), .cmd_resp(cmd_resp), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // expected outcome, in the same priority the protection logic decides
  function automatic eepl_reason_t exp_rs(input eepl_op_t op, input logic [15:0] a);
    logic armed;
    armed = !acr_m[`EEPL_LOCK_BIT];
    if (op == EEPL_OP_READ) return EEPL_OK;
    if (a == `EEPL_ADDR_CFG_NV) return armed ? EEPL_DENY_CFG_LOCK : EEPL_OK;
    if (a == `EEPL_ADDR_DIVH_NV || a == `EEPL_ADDR_DIVL_NV)
      return dsec_m ? EEPL_DENY_DIV_LOCK : EEPL_OK;
    if (a < `EEPL_ARRAY_LO || a > `EEPL_ARRAY_HI) return EEPL_DENY_UNMAPPED;
    if (armed && (op == EEPL_OP_ERASE_BLOCK || op == EEPL_OP_ERASE_BULK))
      return EEPL_DENY_MULTI_ERASE;
    if (armed && a >= `EEPL_SECURE_LO && a <= `EEPL_SECURE_HI) return EEPL_DENY_SECURE;
    if (op == EEPL_OP_ERASE_BULK && |acr_m[3:0]) return EEPL_DENY_BLOCK;
    if (acr_m[a[8:7]]) return EEPL_DENY_BLOCK;
    return EEPL_OK;
  endfunction : exp_rs

  // shared bookkeeping behind the per-kind compare tasks
  task automatic tally(input logic bad, input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (bad) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : tally

  // core access answer: granted, high-voltage start, reason
  task automatic chk_resp(input eepl_resp_t got, input eepl_resp_t exp);
    tally(got !== exp, {29'h0, got}, {29'h0, exp});
  endtask : chk_resp

  // register bus answer: response code above the data word
  task automatic chk_bus(input logic [33:0] got, input logic [33:0] exp);
    tally(got !== exp, got, exp);
  endtask : chk_bus

  // plain output pins
  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    tally(got !== exp, {18'h0, got}, {18'h0, exp});
  endtask : chk_pin

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  // reset copies the nonvolatile bytes, so the expectation model reloads too
  task automatic rst();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    acr_m = cfg_nv;
    dsec_m = !divh_nv[`EEPL_DIVSEC_BIT];
    repeat (2) @(posedge aclk);
  endtask : rst

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    r = rresp;
    d = rdata;
    rready <= 1'b0;
  endtask : axi_rd

  // one core access; a config read reloads the model unless the lock is armed
  task automatic do_req(input eepl_op_t op, input logic [15:0] a);
    eepl_reason_t rs;
    rs = exp_rs(op, a);
    @(posedge aclk);
    cmd_valid <= 1'b1;
    cmd <= '{op, a};
    @(posedge aclk);
    cmd_valid <= 1'b0;
    while (!cmd_done) @(posedge aclk);
    chk_resp(cmd_resp, {rs == EEPL_OK, rs == EEPL_OK && op != EEPL_OP_READ, rs});
    if (op == EEPL_OP_READ && a == `EEPL_ADDR_CFG_NV && acr_m[`EEPL_LOCK_BIT]) acr_m = cfg_nv;
  endtask : do_req

  // hang guard, well past the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    end_of_test();
  end

  initial begin
    rst();
    chk_pin(divider_value, {divh_nv, divl_nv});
    axi_rd(`EEPL_OFF_ACR);
    chk_bus({r, d}, {`EEPL_RESP_OKAY, 24'h0, cfg_nv});
    repeat (60) begin
      rnd = lfsr(rnd);
      do_req(eepl_op_t'(3'(rnd[12:10] % 3'h5)), 16'h0800 + 16'(rnd[9:0]));
    end
    do_req(EEPL_OP_ERASE_BULK, 16'h0800);
    @(posedge aclk);
    cfg_nv <= 8'hf5;
    do_req(EEPL_OP_PROG_BYTE, 16'h0800);
    do_req(EEPL_OP_READ, `EEPL_ADDR_CFG_NV);
    for (int i = 0; i < 4; i++) begin
      do_req(EEPL_OP_PROG_BYTE, 16'h0800 + 16'(i * 128));
      do_req(EEPL_OP_ERASE_BYTE, 16'h087f + 16'(i * 128));
    end
    axi_wr(`EEPL_OFF_DIVL, 32'h56);
    repeat (2) @(posedge aclk);
    chk_bus({r, 16'h0, divider_value}, {`EEPL_RESP_OKAY, 16'h0, divh_nv, 8'h56});
    axi_rd(8'h10);
    chk_bus({r, d}, {`EEPL_RESP_SLVERR, 32'h0});
    // arm the lock with block 0 protected, then hit the secure, config-lock, multi-erase and block refusals
    @(posedge aclk);
    cfg_nv <= 8'he1;
    do_req(EEPL_OP_READ, `EEPL_ADDR_CFG_NV);
    do_req(EEPL_OP_PROG_BYTE, 16'h0800);
    do_req(EEPL_OP_ERASE_BLOCK, 16'h0900);
    do_req(EEPL_OP_ERASE_BULK, 16'h0950);
    do_req(EEPL_OP_PROG_BYTE, 16'h08f5);
    do_req(EEPL_OP_ERASE_BYTE, 16'h08f0);
    do_req(EEPL_OP_READ, 16'h08ff);
    do_req(EEPL_OP_ERASE_BYTE, `EEPL_ADDR_CFG_NV);
    do_req(EEPL_OP_PROG_BYTE, 16'h0900);
    do_req(EEPL_OP_ERASE_BYTE, 16'h08ef);
    @(posedge aclk);
    cfg_nv <= 8'hff;
    do_req(EEPL_OP_READ, `EEPL_ADDR_CFG_NV);
    do_req(EEPL_OP_PROG_BYTE, 16'h0800);
    // a low enable freezes the block: every ready drops and the divider holds
    @(posedge aclk);
    ce <= 1'b0;
    repeat (2) @(posedge aclk);
    chk_pin({13'h0, req_ready, awready, arready}, 16'h0000);
    chk_pin(divider_value, {divh_nv, 8'h56});
    ce <= 1'b1;
    // divider security only takes hold through a reset
    @(posedge aclk);
    divh_nv <= 8'h12;
    rst();
    axi_rd(`EEPL_OFF_DIVH);
    chk_bus({r, d}, {`EEPL_RESP_OKAY, 24'h0, 8'h12});
    axi_wr(`EEPL_OFF_DIVL, 32'h77);
    repeat (2) @(posedge aclk);
    chk_bus({r, 16'h0, divider_value}, {`EEPL_RESP_OKAY, 16'h0, 8'h12, divl_nv});
    do_req(EEPL_OP_PROG_BYTE, `EEPL_ADDR_DIVH_NV);
    do_req(EEPL_OP_ERASE_BYTE, `EEPL_ADDR_DIVL_NV);
    end_of_test();
  end
endmodule : tb_top
